// *** common/stq_pkg.sv ***
package stq_pkg;

   // ----------------------------------------------------------------
   // Time base
   // ----------------------------------------------------------------
   localparam int unsigned CLK_FREQ_MHZ   = 100;
   localparam int unsigned CYC_PER_US     = CLK_FREQ_MHZ;
   localparam int unsigned CYC_PER_MS     = 1000 * CYC_PER_US;

   // ----------------------------------------------------------------
   // Timing figures and their cycle counts
   // ----------------------------------------------------------------
   localparam int unsigned DISC_TIME_MS   = 100;   // Channel mismatch allowance
   localparam int unsigned DISC_CYC       = DISC_TIME_MS * CYC_PER_MS;
   localparam int unsigned OFF_RESP_MS    = 5;     // Stage off after a fall
   localparam int unsigned ON_RESP_US     = 1000;  // Rise registered within
   localparam int unsigned SEQ_DELAY_MS   = 10;    // Sequence delay bound
   localparam int unsigned ENAB_HOLD_MS   = 20;    // Enable low before restart; only flagged on enable_hold_met_o, restart not gated on it
   localparam int unsigned DROP_LO_US     = 500;   // Dropout at low supply
   localparam int unsigned DROP_NOM_US    = 1000;  // Dropout at nominal supply
   localparam int unsigned DROP_HI_US     = 1500;  // Dropout at high supply
   localparam int unsigned DROP_LO_CYC    = DROP_LO_US * CYC_PER_US;
   localparam int unsigned DROP_NOM_CYC   = DROP_NOM_US * CYC_PER_US;
   localparam int unsigned DROP_HI_CYC    = DROP_HI_US * CYC_PER_US;

   // ----------------------------------------------------------------
   // Widths and codes
   // ----------------------------------------------------------------
   localparam int unsigned FILT_W         = 18;
   localparam int unsigned DISC_W         = 24;
   localparam int unsigned MS_W           = 17;
   localparam int unsigned BRAKE_W        = 16;
   localparam int unsigned HOLD_W         = 8;
   localparam logic [1:0]  RANGE_LOW      = 2'h0;
   localparam logic [1:0]  RANGE_NOM      = 2'h1;
   localparam logic [1:0]  RANGE_HIGH     = 2'h2;

   // Sequencer states, Gray along the usual path
   typedef enum logic [2:0] {
      STQ_IDLE    = 3'h0,
      STQ_RELEASE = 3'h1,
      STQ_RUN     = 3'h3,
      STQ_ENGAGE  = 3'h2,
      STQ_CUT     = 3'h6
   } stq_state_t;

endpackage

// *** common/stq_brake_if.sv ***
`timescale 1ns/1ps
interface stq_brake_if;
   logic ms_tick;
   logic release_cmd;
   logic released;
   logic engaged;
   modport ctrl  (output ms_tick, output release_cmd, input released, input engaged);
   modport brake (input ms_tick, input release_cmd, output released, output engaged);
endinterface

// *** hdl/stq_chan_filter.sv ***
`timescale 1ns/1ps
module stq_chan_filter
   import stq_pkg::*;
#(
   parameter int unsigned LO_CYC  = DROP_LO_CYC,
   parameter int unsigned NOM_CYC = DROP_NOM_CYC,
   parameter int unsigned HI_CYC  = DROP_HI_CYC
)(
   input  wire logic       clk_sys_i,
   input  wire logic       sys_rst_i,
   input  wire logic       pin_i,
   input  wire logic [1:0] range_i,
   output logic            level_o
);

   logic              sync1;
   logic              sync2;
   logic              sync3;
   logic [FILT_W-1:0] low_cnt;
   logic [FILT_W-1:0] limit;

   // ----------------------------------------------------------------
   // Three-stage synchroniser
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys_i)
   begin
      if (sys_rst_i)
      begin
         sync1 <= 1'b0;
         sync2 <= 1'b0;
         sync3 <= 1'b0;
      end
      else
      begin
         sync1 <= pin_i;
         sync2 <= sync1;
         sync3 <= sync2;
      end
   end

   // Dropout window by supply range
   always_comb
   begin
      unique case (range_i)
         RANGE_LOW:  limit = FILT_W'(LO_CYC);
         RANGE_NOM:  limit = FILT_W'(NOM_CYC);
         RANGE_HIGH: limit = FILT_W'(HI_CYC);
         default:    limit = FILT_W'(LO_CYC);
      endcase
   end

   // Rise passes at once, fall only after the window
   always_ff @(posedge clk_sys_i)
   begin
      if (sys_rst_i)
      begin
         level_o <= 1'b0;
         low_cnt <= '0;
      end
      else if (sync2 == sync3)
      begin
         if (sync3)
         begin
            level_o <= 1'b1;
            low_cnt <= '0;
         end
         else if (level_o)
         begin
            if (low_cnt >= limit)
               level_o <= 1'b0;
            else
               low_cnt <= low_cnt + FILT_W'(1);
         end
         else
            low_cnt <= '0;
      end
   end

endmodule

// *** hdl/stq_brake_ctrl.sv ***
`timescale 1ns/1ps
module stq_brake_ctrl
   import stq_pkg::*;
(
   input  wire logic               clk_sys_i,
   input  wire logic               sys_rst_i,
   stq_brake_if.brake              bif,
   input  wire logic [BRAKE_W-1:0] release_delay_ms_i,
   input  wire logic [BRAKE_W-1:0] engage_delay_ms_i,
   output logic                    brake_drive_o
);

   logic               cmd_q;
   logic [BRAKE_W:0]   ms_cnt;
   logic               done;

   // ----------------------------------------------------------------
   // Brake drive and delay count
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys_i)
   begin
      if (sys_rst_i)
      begin
         cmd_q         <= 1'b0;
         ms_cnt        <= '0;
         brake_drive_o <= 1'b0;
      end
      else if (bif.release_cmd != cmd_q)
      begin
         cmd_q         <= bif.release_cmd;
         ms_cnt        <= '0;
         brake_drive_o <= bif.release_cmd;
      end
      else if (bif.ms_tick && !done)
         ms_cnt <= ms_cnt + (BRAKE_W+1)'(1);
   end

   // Strictly more ticks than the delay, so it has fully elapsed
   assign done = cmd_q ? (ms_cnt > {1'b0, release_delay_ms_i})
                       : (ms_cnt > {1'b0, engage_delay_ms_i});

   // Released and engaged flags
   always_ff @(posedge clk_sys_i)
   begin
      if (sys_rst_i)
      begin
         bif.released <= 1'b0;
         bif.engaged  <= 1'b1;
      end
      else
      begin
         bif.released <= cmd_q && (bif.release_cmd == cmd_q) && done;
         bif.engaged  <= !cmd_q && (bif.release_cmd == cmd_q) && done;
      end
   end

endmodule

// *** hdl/stq_sequencer.sv ***
`timescale 1ns/1ps
module stq_sequencer
   import stq_pkg::*;
#(
   parameter int unsigned MS_CYC       = CYC_PER_MS,
   parameter int unsigned DISC_LIMIT   = DISC_CYC,
   parameter int unsigned DROP_LO      = DROP_LO_CYC,
   parameter int unsigned DROP_NOM     = DROP_NOM_CYC,
   parameter int unsigned DROP_HI      = DROP_HI_CYC
)(
   input  wire logic               clk_sys_i,
   input  wire logic               sys_rst_i,
   input  wire logic               torque_cut_channel_a_i,
   input  wire logic               torque_cut_channel_b_i,
   input  wire logic               drive_enable_input_i,
   input  wire logic               bus_enable_i,
   input  wire logic               enable_from_bus_i,
   input  wire logic [1:0]         supply_range_i,
   input  wire logic [BRAKE_W-1:0] brake_release_delay_ms_i,
   input  wire logic [BRAKE_W-1:0] brake_engage_delay_ms_i,
   input  wire logic               error_clear_i,
   output logic                    output_stage_en_o,
   output logic                    setpoint_enable_o,
   output logic                    brake_drive_o,
   output logic                    discrepancy_error_o,
   output logic                    cut_while_active_error_o,
   output logic                    channel_a_level_o,
   output logic                    channel_b_level_o,
   output logic                    restart_armed_o,
   output logic                    enable_hold_met_o,
   output logic [2:0]              seq_state_o
);

   stq_brake_if    bif ();

   stq_state_t     state;
   stq_state_t     next_state;
   logic           chan_a;
   logic           chan_b;
   logic           both_high;
   logic           both_high_q;
   logic           cut_event;
   logic           mismatch;
   logic [DISC_W-1:0] disc_cnt;
   logic           disc_set;
   logic           en_sync1;
   logic           en_sync2;
   logic           en_sync3;
   logic           en_pin;
   logic           enable;
   logic           enable_q;
   logic           en_rise;
   logic [MS_W-1:0] ms_pre;
   logic           ms_tick;
   logic [HOLD_W-1:0] hold_cnt;
   logic           stage_active;

   // ----------------------------------------------------------------
   // Channel inputs
   // ----------------------------------------------------------------

   // Identical filters on both channels
   stq_chan_filter #(
      .LO_CYC  (DROP_LO),
      .NOM_CYC (DROP_NOM),
      .HI_CYC  (DROP_HI)
   ) u_filt_a (
      .clk_sys_i (clk_sys_i),
      .sys_rst_i (sys_rst_i),
      .pin_i     (torque_cut_channel_a_i),
      .range_i   (supply_range_i),
      .level_o   (chan_a)
   );

   stq_chan_filter #(
      .LO_CYC  (DROP_LO),
      .NOM_CYC (DROP_NOM),
      .HI_CYC  (DROP_HI)
   ) u_filt_b (
      .clk_sys_i (clk_sys_i),
      .sys_rst_i (sys_rst_i),
      .pin_i     (torque_cut_channel_b_i),
      .range_i   (supply_range_i),
      .level_o   (chan_b)
   );

   // Symmetric combinations of the two channels
   assign both_high = chan_a & chan_b;
   assign mismatch  = chan_a ^ chan_b;
   assign cut_event = both_high_q & !both_high;

   // Previous combined level
   always_ff @(posedge clk_sys_i)
   begin
      if (sys_rst_i)
         both_high_q <= 1'b0;
      else
         both_high_q <= both_high;
   end

   // ----------------------------------------------------------------
   // Drive enable input
   // ----------------------------------------------------------------

   // Pin synchroniser, change taken when stages two and three agree
   always_ff @(posedge clk_sys_i)
   begin
      if (sys_rst_i)
      begin
         en_sync1 <= 1'b0;
         en_sync2 <= 1'b0;
         en_sync3 <= 1'b0;
         en_pin   <= 1'b0;
      end
      else
      begin
         en_sync1 <= drive_enable_input_i;
         en_sync2 <= en_sync1;
         en_sync3 <= en_sync2;
         if (en_sync2 == en_sync3)
            en_pin <= en_sync3;
      end
   end

   // Source select, hardware pin or bus
   assign enable  = enable_from_bus_i ? bus_enable_i : en_pin;
   assign en_rise = enable & !enable_q;

   // Enable edge history
   always_ff @(posedge clk_sys_i)
   begin
      if (sys_rst_i)
         enable_q <= 1'b0;
      else
         enable_q <= enable;
   end

   // ----------------------------------------------------------------
   // Millisecond time base
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys_i)
   begin
      if (sys_rst_i)
         ms_pre <= '0;
      else if (ms_tick)
         ms_pre <= '0;
      else
         ms_pre <= ms_pre + MS_W'(1);
   end

   assign ms_tick     = (ms_pre == MS_W'(MS_CYC - 1));
   assign bif.ms_tick = ms_tick;

   // ----------------------------------------------------------------
   // Discrepancy monitor
   // ----------------------------------------------------------------

   // Mismatch duration, saturating
   always_ff @(posedge clk_sys_i)
   begin
      if (sys_rst_i)
         disc_cnt <= '0;
      else if (!mismatch)
         disc_cnt <= '0;
      else if (!disc_set)
         disc_cnt <= disc_cnt + DISC_W'(1);
   end

   // Set once the mismatch outlasts the allowance
   assign disc_set = mismatch && (disc_cnt >= DISC_W'(DISC_LIMIT));

   // ----------------------------------------------------------------
   // Error flags, set wins over clear
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys_i)
   begin
      if (sys_rst_i)
         discrepancy_error_o <= 1'b0;
      else if (disc_set)
         discrepancy_error_o <= 1'b1;
      else if (error_clear_i)
         discrepancy_error_o <= 1'b0;
   end

   always_ff @(posedge clk_sys_i)
   begin
      if (sys_rst_i)
         cut_while_active_error_o <= 1'b0;
      else if (cut_event && stage_active)
         cut_while_active_error_o <= 1'b1;
      else if (error_clear_i)
         cut_while_active_error_o <= 1'b0;
   end

   // ----------------------------------------------------------------
   // Restart arming
   // ----------------------------------------------------------------

   // Armed only with both channels high and the enable low
   always_ff @(posedge clk_sys_i)
   begin
      if (sys_rst_i)
         restart_armed_o <= 1'b0;
      else if (!both_high || discrepancy_error_o || state == STQ_RELEASE)
         restart_armed_o <= 1'b0;
      else if (!enable && (state == STQ_IDLE || state == STQ_CUT))
         restart_armed_o <= 1'b1;
   end

   // Enable low time since arming, informational
   always_ff @(posedge clk_sys_i)
   begin
      if (sys_rst_i)
         hold_cnt <= '0;
      else if (!restart_armed_o || enable)
         hold_cnt <= '0;
      else if (ms_tick && !enable_hold_met_o)
         hold_cnt <= hold_cnt + HOLD_W'(1);
   end

   assign enable_hold_met_o = (hold_cnt > HOLD_W'(ENAB_HOLD_MS));

   // ----------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------

   // Next state, one cycle per transition
   always_comb
   begin
      next_state = state;
      unique case (state)
         STQ_IDLE, STQ_CUT:
         begin
            if (restart_armed_o && en_rise && both_high)
               next_state = STQ_RELEASE;
         end
         STQ_RELEASE:
         begin
            if (!both_high || discrepancy_error_o)
               next_state = STQ_CUT;
            else if (!enable)
               next_state = STQ_ENGAGE;
            else if (bif.released)
               next_state = STQ_RUN;
         end
         STQ_RUN:
         begin
            if (!both_high || discrepancy_error_o)
               next_state = STQ_CUT;
            else if (!enable)
               next_state = STQ_ENGAGE;
         end
         STQ_ENGAGE:
         begin
            if (!both_high || discrepancy_error_o)
               next_state = STQ_CUT;
            else if (bif.engaged)
               next_state = STQ_IDLE;
         end
      endcase
   end

   // State register
   always_ff @(posedge clk_sys_i)
   begin
      if (sys_rst_i)
         state <= STQ_IDLE;
      else
         state <= next_state;
   end

   assign stage_active = output_stage_en_o;

   // Output stage and setpoint release
   always_ff @(posedge clk_sys_i)
   begin
      if (sys_rst_i)
      begin
         output_stage_en_o <= 1'b0;
         setpoint_enable_o <= 1'b0;
      end
      else
      begin
         output_stage_en_o <= (next_state == STQ_RELEASE) ||
                              (next_state == STQ_RUN) ||
                              (next_state == STQ_ENGAGE);
         setpoint_enable_o <= (next_state == STQ_RUN);
      end
   end

   // Brake command from the ordinary sequence
   always_ff @(posedge clk_sys_i)
   begin
      if (sys_rst_i)
         bif.release_cmd <= 1'b0;
      else
         bif.release_cmd <= (next_state == STQ_RELEASE) ||
                            (next_state == STQ_RUN);
   end

   stq_brake_ctrl u_brake (
      .clk_sys_i          (clk_sys_i),
      .sys_rst_i          (sys_rst_i),
      .bif                (bif),
      .release_delay_ms_i (brake_release_delay_ms_i),
      .engage_delay_ms_i  (brake_engage_delay_ms_i),
      .brake_drive_o      (brake_drive_o)
   );

   // ----------------------------------------------------------------
   // Status
   // ----------------------------------------------------------------
   assign channel_a_level_o = chan_a;
   assign channel_b_level_o = chan_b;
   assign seq_state_o       = state;

endmodule

// *** test/stq_seq_properties.sv ***
`timescale 1ns/1ps
module stq_seq_properties
   import stq_pkg::*;
#(
   parameter int unsigned MS_CYC     = CYC_PER_MS,
   parameter int unsigned DISC_LIMIT = DISC_CYC,
   parameter int unsigned DROP_LO    = DROP_LO_CYC,
   parameter int unsigned DROP_NOM   = DROP_NOM_CYC,
   parameter int unsigned DROP_HI    = DROP_HI_CYC
)(
   input wire logic               clk_sys_i,
   input wire logic               sys_rst_i,
   input wire logic               torque_cut_channel_a_i,
   input wire logic               torque_cut_channel_b_i,
   input wire logic               drive_enable_input_i,
   input wire logic               bus_enable_i,
   input wire logic               enable_from_bus_i,
   input wire logic [1:0]         supply_range_i,
   input wire logic [BRAKE_W-1:0] brake_release_delay_ms_i,
   input wire logic [BRAKE_W-1:0] brake_engage_delay_ms_i,
   input wire logic               error_clear_i,
   input wire logic               output_stage_en_o,
   input wire logic               setpoint_enable_o,
   input wire logic               brake_drive_o,
   input wire logic               discrepancy_error_o,
   input wire logic               cut_while_active_error_o,
   input wire logic               channel_a_level_o,
   input wire logic               channel_b_level_o,
   input wire logic               restart_armed_o,
   input wire logic               enable_hold_met_o,
   input wire logic [2:0]         seq_state_o
);
   int lo_a;
   int lo_b;
   int mis;
   int brk;
   int eng;

   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (sys_rst_i);

   // --------------------
   // Run-length counters
   // --------------------
   // Pin low spans
   always_ff @(posedge clk_sys_i)
   begin
      lo_a <= torque_cut_channel_a_i ? 0 : lo_a + 1;
      lo_b <= torque_cut_channel_b_i ? 0 : lo_b + 1;
   end
   // Level mismatch span
   always_ff @(posedge clk_sys_i)
   begin
      mis <= (channel_a_level_o != channel_b_level_o) ? mis + 1 : 0;
   end
   // Brake released and engaged spans
   always_ff @(posedge clk_sys_i)
   begin
      brk <= brake_drive_o ? brk + 1 : 0;
      eng <= brake_drive_o ? 0 : eng + 1;
   end

   // --------------------
   // Properties
   // --------------------
   a_rise_a_seen: assert property ($rose(torque_cut_channel_a_i) ##1
      torque_cut_channel_a_i[*7] |-> channel_a_level_o) else $error("channel a rise missed");
   a_rise_b_seen: assert property ($rose(torque_cut_channel_b_i) ##1
      torque_cut_channel_b_i[*7] |-> channel_b_level_o) else $error("channel b rise missed");
   a_dropout_kept: assert property ($fell(channel_a_level_o) |-> lo_a > DROP_LO)
      else $error("channel a fell on a short dropout");
   a_low_stage_off: assert property ((lo_a > DROP_HI + 12 || lo_b > DROP_HI + 12)
      |-> !output_stage_en_o) else $error("stage on with a channel low");
   a_disc_too_early: assert property ($rose(discrepancy_error_o) |-> mis > DISC_LIMIT)
      else $error("discrepancy flagged inside window");
   a_disc_missed: assert property (mis == DISC_LIMIT + 6 |-> discrepancy_error_o)
      else $error("discrepancy not flagged");
   a_cut_error_set: assert property ($fell(channel_a_level_o && channel_b_level_o)
      && output_stage_en_o |-> ##[1:3] cut_while_active_error_o) else $error("no cut error");
   a_cut_state_fast: assert property ($fell(channel_a_level_o && channel_b_level_o)
      && output_stage_en_o |-> ##[1:3] seq_state_o == STQ_CUT) else $error("cut state late");
   a_release_delay: assert property ($rose(setpoint_enable_o) |->
      brk + 2 >= int'(brake_release_delay_ms_i) * MS_CYC
      && brk <= (int'(brake_release_delay_ms_i) + 1) * MS_CYC + 2)
      else $error("setpoint outside release delay");
   a_engage_delay: assert property ($fell(output_stage_en_o) && seq_state_o == STQ_IDLE
      && $past(seq_state_o) == STQ_ENGAGE |-> eng + 3 >= int'(brake_engage_delay_ms_i) * MS_CYC
      && eng <= (int'(brake_engage_delay_ms_i) + 1) * MS_CYC + 3)
      else $error("stage off outside engage delay");
   a_restart_gated: assert property ($rose(output_stage_en_o) |->
      channel_a_level_o && channel_b_level_o && !discrepancy_error_o
      && $past(seq_state_o) inside {STQ_IDLE, STQ_CUT}) else $error("stage on without restart");

   c_setpoint: cover property ($rose(setpoint_enable_o));
   c_disc: cover property ($rose(discrepancy_error_o));
   c_cut_error: cover property ($rose(cut_while_active_error_o));
endmodule

bind stq_sequencer stq_seq_properties #(
   .MS_CYC(MS_CYC), .DISC_LIMIT(DISC_LIMIT), .DROP_LO(DROP_LO), .DROP_NOM(DROP_NOM),
   .DROP_HI(DROP_HI)
) u_props (.*);

// *** test/stq_relay_model.sv ***
`timescale 1ns/1ps
module stq_relay_model
#(
   parameter int unsigned HOLD_CYC = 2200
)(
   input  wire logic clk_sys_i,
   output logic      chan_a_o,
   output logic      chan_b_o,
   output logic      enable_o
);
   // Channels and enable start low
   initial
   begin
      chan_a_o = 1'b0;
      chan_b_o = 1'b0;
      enable_o = 1'b0;
   end
   // Both channels together, enable left as it is
   task automatic set_chan(input logic v);
      @(negedge clk_sys_i);
      chan_a_o = v;
      chan_b_o = v;
   endtask
   // Enable level
   task automatic set_en(input logic v);
      @(negedge clk_sys_i);
      enable_o = v;
   endtask
   // One channel low for a span of cycles
   task automatic drop(input logic on_b, input int cyc);
      @(negedge clk_sys_i);
      if (on_b)
         chan_b_o = 1'b0;
      else
         chan_a_o = 1'b0;
      repeat (cyc) @(negedge clk_sys_i);
      chan_a_o = 1'b1;
      chan_b_o = 1'b1;
   endtask
   // Channels back, enable held low past the restart hold
   task automatic arm;
      @(negedge clk_sys_i);
      enable_o = 1'b0;
      chan_a_o = 1'b1;
      chan_b_o = 1'b1;
      repeat (HOLD_CYC) @(negedge clk_sys_i);
   endtask
endmodule

// *** test/tb.sv ***
`timescale 1ns/1ps
module tb
   import stq_pkg::*;
;
   localparam int unsigned MSC = 100;
   logic               clk_sys_i;
   logic               sys_rst_i;
   logic               torque_cut_channel_a_i;
   logic               torque_cut_channel_b_i;
   logic               drive_enable_input_i;
   logic               bus_enable_i;
   logic               enable_from_bus_i;
   logic [1:0]         supply_range_i;
   logic [BRAKE_W-1:0] brake_release_delay_ms_i;
   logic [BRAKE_W-1:0] brake_engage_delay_ms_i;
   logic               error_clear_i;
   logic               output_stage_en_o;
   logic               setpoint_enable_o;
   logic               brake_drive_o;
   logic               discrepancy_error_o;
   logic               cut_while_active_error_o;
   logic               channel_a_level_o;
   logic               channel_b_level_o;
   logic               restart_armed_o;
   logic               enable_hold_met_o;
   logic [2:0]         seq_state_o;
   logic               relay_en;
   int                 fails;
   int                 num_checks;
   int                 seed;
   int                 n;
   int                 d;
   int                 dly_q[$];

   // Enable reaches the design by pin or by bus, the unused source inverted
   assign drive_enable_input_i = enable_from_bus_i ? !relay_en : relay_en;
   assign bus_enable_i         = enable_from_bus_i ? relay_en : !relay_en;

   // Default hold of 2200 cycles is 22 ms at this bench's millisecond
   stq_relay_model relay (
      .clk_sys_i(clk_sys_i),
      .chan_a_o (torque_cut_channel_a_i),
      .chan_b_o (torque_cut_channel_b_i),
      .enable_o (relay_en)
   );

   stq_sequencer #(
      .MS_CYC(MSC), .DISC_LIMIT(500), .DROP_LO(20), .DROP_NOM(40), .DROP_HI(60)
   ) uut (.*);

   // Clock
   initial
   begin
      clk_sys_i = 1'b0;
      forever #5 clk_sys_i = ~clk_sys_i;
   end

   // --------------------
   // Helpers
   // --------------------
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
         fails++;
      end
   endtask

   function automatic logic pick(input int s);
      return (s == 0) ? output_stage_en_o : setpoint_enable_o;
   endfunction

   task automatic wait_sig(input int s, input logic v, input int lim, output int cnt);
      cnt = 0;
      while (pick(s) !== v && cnt < lim)
      begin
         @(negedge clk_sys_i);
         cnt++;
      end
   endtask

   task automatic print_verdict;
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // Restart through the hold, then timed brake release
   task automatic restart(input logic sel);
      enable_from_bus_i = sel;
      brake_release_delay_ms_i = BRAKE_W'(1 + $unsigned($random(seed)) % 3);
      dly_q.push_back(int'(brake_release_delay_ms_i));
      error_clear_i = 1'b1;
      relay.arm();
      error_clear_i = 1'b0;
      check("hold met and armed", {enable_hold_met_o, restart_armed_o}, 2'h3);
      relay.set_en(1'b1);
      d = dly_q.pop_front();
      wait_sig(1, 1'b1, (d + 2) * MSC, n);
      check("release time", n >= d * MSC && n <= (d + 1) * MSC + 10, 1'b1);
      check("run outputs", {output_stage_en_o, brake_drive_o, seq_state_o, discrepancy_error_o,
         cut_while_active_error_o}, 7'h6c);
   endtask

   // --------------------
   // Main sequence
   // --------------------
   initial
   begin
      seed = 35542;
      fails = 0;
      num_checks = 0;
      sys_rst_i = 1'b1;
      enable_from_bus_i = 1'b0;
      supply_range_i = RANGE_NOM;
      brake_release_delay_ms_i = 16'h0001;
      brake_engage_delay_ms_i = 16'h0000;
      error_clear_i = 1'b0;
      repeat (16) @(negedge clk_sys_i);
      sys_rst_i = 1'b0;
      check("reset outputs", {output_stage_en_o, setpoint_enable_o, brake_drive_o,
         discrepancy_error_o, cut_while_active_error_o, seq_state_o}, 8'h00);
      restart(1'b0);
      for (int r = 0; r < 4; r++)
      begin
         supply_range_i = 2'(r);
         relay.drop(r[0], (r == 1) ? 40 : (r == 2) ? 60 : 20);
         repeat (20) @(negedge clk_sys_i);
         check("dropout ignored", {output_stage_en_o, setpoint_enable_o, discrepancy_error_o,
            cut_while_active_error_o, channel_a_level_o, channel_b_level_o}, 6'h33);
      end
      supply_range_i = RANGE_NOM;
      relay.set_chan(1'b0);
      wait_sig(0, 1'b0, 600, n);
      check("cut response", n >= 40 && n <= 60, 1'b1);
      repeat (5) @(negedge clk_sys_i);
      check("cut error", {cut_while_active_error_o, seq_state_o}, 4'he);
      relay.set_chan(1'b1);
      repeat (300) @(negedge clk_sys_i);
      check("no restart without enable edge", {output_stage_en_o, restart_armed_o}, 2'h0);
      restart(1'b1);
      brake_engage_delay_ms_i = BRAKE_W'($unsigned($random(seed)) % 3);
      d = int'(brake_engage_delay_ms_i);
      relay.set_en(1'b0);
      wait_sig(0, 1'b0, (d + 2) * MSC, n);
      check("engage time", n >= d * MSC && n <= (d + 1) * MSC + 10, 1'b1);
      check("idle outputs", {setpoint_enable_o, brake_drive_o, seq_state_o}, 5'h00);
      relay.drop(1'b1, 450);
      repeat (20) @(negedge clk_sys_i);
      check("short mismatch", discrepancy_error_o, 1'b0);
      relay.drop(1'b0, 700);
      repeat (20) @(negedge clk_sys_i);
      check("long mismatch", discrepancy_error_o, 1'b1);
      print_verdict();
   end

   // Watchdog
   initial
   begin
      repeat (40000) @(posedge clk_sys_i);
      fails++;
      print_verdict();
   end
endmodule
